// ### verilog/tlct_regs.svh
`ifndef TLCT_REGS_SVH
`define TLCT_REGS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define TLCT_OFF_CTRL      8'h00
`define TLCT_OFF_TLB_IDX  8'h04
`define TLCT_OFF_TLB_VTAG 8'h08
`define TLCT_OFF_TLB_PPN  8'h0c
`define TLCT_OFF_TEST     8'h10
`define TLCT_OFF_LAST_PA  8'h14

// ---------------------------------------------------------------
// Reset values and fields
// ---------------------------------------------------------------
`define TLCT_CTRL_RESET   32'h0000_0003
`define TLCT_CTRL_XLATE   0
`define TLCT_CTRL_VHIT    1
`define TLCT_PPN_WPROT    29
`define TLCT_PPN_SUPER    30
`define TLCT_PPN_VALID    31

// ---------------------------------------------------------------
// Space identifiers that allow a virtual hit
// ---------------------------------------------------------------
`define TLCT_ASI_USER_INSTR  8'h08
`define TLCT_ASI_SUPER_INSTR 8'h09
`define TLCT_ASI_USER_DATA   8'h0a
`define TLCT_ASI_SUPER_DATA  8'h0b

`endif

// ### verilog/tlct_pkg.sv
`default_nettype none
package tlct_pkg;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        user;
    logic        tag_update;
    logic [7:0]  space_id;
    logic [31:0] addr;
    logic [31:0] data;
  } tlct_cpu_req_type;

  typedef struct packed {
    logic translation_match;
    logic virt_tag_match;
    logic phys_tag_match;
    logic virt_hit;
    logic phys_hit;
    logic virt_miss;
    logic phys_miss;
    logic write_fault;
    logic user_fault;
    logic cache_write_dirty;
  } tlct_flags_type;

  typedef struct packed {
    logic        valid;
    logic        write_protect;
    logic        super_only;
    logic [15:0] vtag;
    logic [18:0] ppn;
  } tlct_tlb_entry_type;

  typedef struct packed {
    logic        phys_valid;
    logic        virt_valid;
    logic        owned;
    logic [15:0] vtag;
    logic [18:0] ptag;
  } tlct_tag_entry_type;

  typedef enum logic [1:0] {
    tlct_resp_okay   = 2'b00,
    tlct_resp_slverr = 2'b10
  } tlct_resp_type;

endpackage : tlct_pkg
`default_nettype wire

// ### verilog/tlct_top.sv
// Functional notes
// - Compare lookup address with stored translation entry; flag translation_match on agreement.
// - On successful translation drive physical address onto physical_address_bus.
// - Test info latch captures status; diagnostic read presents it on control_data_bus.
// - Pass processor 8-bit space identifier onto latched_space_id.
// - Virtual, physical and valid tag stores indexed by tag index bits 15:5.
// - Tag update writes upper two bytes of lookup address into virtual tags.
// - Tag update writes translated physical tag into physical tag store.
// - Each line holds physical valid, virtual valid, ownership bits for hit logic; the hit logic reads only the two valid bits.
// - Physical match when stored tag equals physical address bits 31:13.
// - Virtual match when stored tag equals lookup address bits 31:16.
// - Hit logic combines consistency status into hit and miss indications.
// - Three low cache address bits decode to eight one-hot chip selects.
// - Cache word built from two 32-bit transfers, low half then high half.
// - Cache address bit 2 low loads low half, high loads high half.
// - Dirty output asserted during every processor write into cache.
// - Cache data split into separate low and high banks.
// - Upper three cache address bits merged into lookup address bits 13-15.
// - Current processor space identifier (cpu_req.space_id) decides the two virtual hit enables.
// - Write-protection and user-protection violations reported as faults.
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`default_nettype none
`include "tlct_regs.svh"

module tlct_top (
  input  wire logic                       clk_sys,
  input  wire logic                       rstn,
  input  wire logic                       clk_en,
  input  wire logic [7:0]                 s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [7:0]                 s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire tlct_pkg::tlct_cpu_req_type cpu_req,
  input  wire logic                       consist_hold,
  input  wire logic                       diag_read,
  output tlct_pkg::tlct_flags_type        access_flags,
  output logic [31:0]                     physical_address_bus,
  output logic [7:0]                      latched_space_id,
  output logic [7:0]                      bank_chip_select,
  output logic [31:0]                     cache_data_low,
  output logic [31:0]                     cache_data_high,
  output logic [31:0]                     control_data_bus
);
  import tlct_pkg::*;

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  logic [31:0]        ctrl;
  logic [2:0]         tlb_index;
  logic [15:0]        tlb_vtag;
  logic [31:0]        tlb_ppn;
  logic [31:0]        test_info_latch;
  tlct_tlb_entry_type tlb_mem [8];
  tlct_tag_entry_type tag_mem [2048];

  // ---------------------------------------------------------------
  // Lookup path
  // ---------------------------------------------------------------
  wire logic [15:0]   cache_line_address = cpu_req.addr[15:0];
  wire logic [31:0]   lookup_address_bus = {cpu_req.addr[31:16], cache_line_address[15:13],
                                            cpu_req.addr[12:0]};
  wire logic [2:0]    tlb_sel            = lookup_address_bus[15:13];
  tlct_tlb_entry_type tlb_entry;
  assign tlb_entry = tlb_mem[tlb_sel];
  wire logic          xlate_en           = ctrl[`TLCT_CTRL_XLATE];

  wire logic          next_translation_match        = cpu_req.valid
                                           & (~xlate_en | (tlb_entry.valid
                                           & (tlb_entry.vtag == lookup_address_bus[31:16])));
  wire logic [18:0]   trans_ppn          = xlate_en ? tlb_entry.ppn : lookup_address_bus[31:13];
  wire logic [31:0]   next_pa            = {trans_ppn, lookup_address_bus[12:0]};

  wire logic [15:0]   tag_index_bus      = lookup_address_bus[15:0];
  wire logic [10:0]   tag_idx            = tag_index_bus[15:5];
  tlct_tag_entry_type tag_entry;
  assign tag_entry = tag_mem[tag_idx];
  wire logic [15:0]   virtual_tag_bus    = lookup_address_bus[31:16];
  wire logic [18:0]   physical_tag_bus   = next_pa[31:13];

  wire logic          next_virt_tag_match        = cpu_req.valid & (tag_entry.vtag == virtual_tag_bus);
  wire logic          next_phys_tag_match        = next_translation_match & (tag_entry.ptag == physical_tag_bus);

  // Two virtual hit enables from the space identifier
  wire logic          vhit_en_user       = (cpu_req.space_id == `TLCT_ASI_USER_INSTR)
                                           | (cpu_req.space_id == `TLCT_ASI_USER_DATA);
  wire logic          vhit_en_super      = (cpu_req.space_id == `TLCT_ASI_SUPER_INSTR)
                                           | (cpu_req.space_id == `TLCT_ASI_SUPER_DATA);
  wire logic          vhit_allowed       = (vhit_en_user | vhit_en_super) & ctrl[`TLCT_CTRL_VHIT];

  wire logic          next_vhit          = next_virt_tag_match & tag_entry.virt_valid & vhit_allowed
                                           & ~consist_hold;
  wire logic          next_phit          = next_phys_tag_match & tag_entry.phys_valid & ~consist_hold;

  wire logic          next_wfault        = next_translation_match & xlate_en & cpu_req.write
                                           & tlb_entry.write_protect;
  wire logic          next_ufault        = next_translation_match & xlate_en & cpu_req.user
                                           & tlb_entry.super_only;
  wire logic          cache_store        = cpu_req.valid & cpu_req.write & ~cpu_req.tag_update
                                           & ~next_wfault & ~next_ufault;

  tlct_flags_type     next_flags;
  assign next_flags = '{translation_match: next_translation_match,
                        virt_tag_match:    next_virt_tag_match,
                        phys_tag_match:    next_phys_tag_match,
                        virt_hit:          next_vhit,
                        phys_hit:          next_phit,
                        virt_miss:         cpu_req.valid & ~next_vhit,
                        phys_miss:         cpu_req.valid & ~next_phit,
                        write_fault:       next_wfault,
                        user_fault:        next_ufault,
                        cache_write_dirty: cache_store};

  wire logic [7:0]    next_cs            = cpu_req.valid ? (8'h01 << cache_line_address[2:0]) : 8'h00;

  // ---------------------------------------------------------------
  // Access outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      access_flags         <= '0;
      physical_address_bus <= 32'h0000_0000;
      latched_space_id     <= 8'h00;
      bank_chip_select     <= 8'h00;
    end else if (clk_en) begin
      access_flags         <= next_flags;
      physical_address_bus <= next_translation_match ? next_pa : 32'h0000_0000;
      bank_chip_select     <= next_cs;
      if (cpu_req.valid) begin
        latched_space_id <= cpu_req.space_id;
      end
    end
  end

  // Low half on bit 2 clear, high half on bit 2 set, each its own bank
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cache_data_low  <= 32'h0000_0000;
      cache_data_high <= 32'h0000_0000;
    end else if (clk_en && cache_store) begin
      if (cpu_req.addr[2]) begin
        cache_data_high <= cpu_req.data;
      end else begin
        cache_data_low  <= cpu_req.data;
      end
    end
  end

  // ---------------------------------------------------------------
  // Tag stores
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      for (int i = 0; i < 2048; i++) begin
        tag_mem[i] <= '0;
      end
    end else if (clk_en && cpu_req.valid && cpu_req.tag_update) begin
      tag_mem[tag_idx] <= '{phys_valid: next_translation_match, virt_valid: 1'b1, owned: cpu_req.write,
                            vtag: virtual_tag_bus, ptag: physical_tag_bus};
    end
  end

  // ---------------------------------------------------------------
  // Test information latch
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      test_info_latch  <= 32'h0000_0000;
      control_data_bus <= 32'h0000_0000;
    end else if (clk_en) begin
      if (cpu_req.valid) begin
        test_info_latch <= {cpu_req.space_id, next_cs, 6'h00, next_flags};
      end
      control_data_bus <= diag_read ? test_info_latch : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;

  function automatic logic [31:0] tlct_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : tlct_merge

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  wire logic [7:0]  wr_addr   = {aw_addr_q[7:2], 2'b00};
  wire logic        wr_go     = aw_held & w_held & ~s_axi_bvalid;
  wire logic        wr_ctrl   = wr_go & (wr_addr == `TLCT_OFF_CTRL);
  wire logic        wr_idx    = wr_go & (wr_addr == `TLCT_OFF_TLB_IDX);
  wire logic        wr_vtag   = wr_go & (wr_addr == `TLCT_OFF_TLB_VTAG);
  wire logic        wr_ppn    = wr_go & (wr_addr == `TLCT_OFF_TLB_PPN);
  wire logic        wr_known  = wr_ctrl | wr_idx | wr_vtag | wr_ppn
                                | (wr_addr == `TLCT_OFF_TEST) | (wr_addr == `TLCT_OFF_LAST_PA);
  wire logic [31:0] ppn_value = tlct_merge(tlb_ppn, w_data_q, w_strb_q);
  wire logic [31:0] vtag_value = tlct_merge({16'h0000, tlb_vtag}, w_data_q, w_strb_q);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held   <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held   <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= tlct_resp_okay;
    end else if (clk_en) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? tlct_resp_okay : tlct_resp_slverr;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ctrl      <= `TLCT_CTRL_RESET;
      tlb_index <= 3'h0;
      tlb_vtag  <= 16'h0000;
      tlb_ppn   <= 32'h0000_0000;
      for (int i = 0; i < 8; i++) begin
        tlb_mem[i] <= '0;
      end
    end else if (clk_en) begin
      if (wr_ctrl) begin
        ctrl <= tlct_merge(ctrl, w_data_q, w_strb_q);
      end
      if (wr_idx && w_strb_q[0]) begin
        tlb_index <= w_data_q[2:0];
      end
      if (wr_vtag) begin
        tlb_vtag <= vtag_value[15:0];
      end
      if (wr_ppn) begin
        // Entry committed with the staged virtual tag
        tlb_ppn            <= ppn_value;
        tlb_mem[tlb_index] <= '{valid: ppn_value[`TLCT_PPN_VALID],
                               write_protect: ppn_value[`TLCT_PPN_WPROT],
                               super_only: ppn_value[`TLCT_PPN_SUPER],
                               vtag: tlb_vtag, ppn: ppn_value[18:0]};
      end
    end
  end

  wire logic [7:0] rd_addr = {s_axi_araddr[7:2], 2'b00};
  wire logic       rd_ctrl = rd_addr == `TLCT_OFF_CTRL;
  wire logic       rd_idx  = rd_addr == `TLCT_OFF_TLB_IDX;
  wire logic       rd_vtag = rd_addr == `TLCT_OFF_TLB_VTAG;
  wire logic       rd_ppn  = rd_addr == `TLCT_OFF_TLB_PPN;
  wire logic       rd_test = rd_addr == `TLCT_OFF_TEST;
  wire logic       rd_pa   = rd_addr == `TLCT_OFF_LAST_PA;
  wire logic       rd_ok   = rd_ctrl | rd_idx | rd_vtag | rd_ppn | rd_test | rd_pa;
  wire logic [31:0] rd_data = ({32{rd_ctrl}} & ctrl)
                              | ({32{rd_idx}}  & {29'h0000_0000, tlb_index})
                              | ({32{rd_vtag}} & {16'h0000, tlb_vtag})
                              | ({32{rd_ppn}}  & tlb_ppn)
                              | ({32{rd_test}} & test_info_latch)
                              | ({32{rd_pa}}   & physical_address_bus);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= tlct_resp_okay;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_data;
        s_axi_rresp  <= rd_ok ? tlct_resp_okay : tlct_resp_slverr;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  property p_translation_match;
    clk_en && cpu_req.valid && xlate_en && tlb_entry.valid && tlb_entry.vtag == cpu_req.addr[31:16]
      |=> access_flags.translation_match;
  endproperty
  a_translation_match: assert property (p_translation_match) else $error("translation match missing");

  property p_pa;
    clk_en && next_translation_match |=> physical_address_bus[12:0] == $past(cpu_req.addr[12:0])
      && physical_address_bus[31:13] == $past(trans_ppn);
  endproperty
  a_pa: assert property (p_pa) else $error("physical address wrong");

  property p_diag;
    clk_en && diag_read |=> control_data_bus == $past(test_info_latch);
  endproperty
  a_diag: assert property (p_diag) else $error("test info not presented");

  property p_space;
    clk_en && cpu_req.valid |=> latched_space_id == $past(cpu_req.space_id);
  endproperty
  a_space: assert property (p_space) else $error("space id not latched");

  property p_tag_back;
    clk_en && cpu_req.valid && cpu_req.tag_update ##1
      clk_en && cpu_req.valid && !cpu_req.tag_update && cpu_req.addr == $past(cpu_req.addr)
      |=> access_flags.virt_tag_match;
  endproperty
  a_tag_back: assert property (p_tag_back) else $error("updated tag does not match");

  property p_cs;
    clk_en && cpu_req.valid |=> $onehot(bank_chip_select)
      && bank_chip_select[$past(cpu_req.addr[2:0])];
  endproperty
  a_cs: assert property (p_cs) else $error("chip select decode wrong");

  property p_low_half;
    clk_en && cache_store && !cpu_req.addr[2] |=> cache_data_low == $past(cpu_req.data)
      && $stable(cache_data_high);
  endproperty
  a_low_half: assert property (p_low_half) else $error("low half not loaded");

  property p_dirty;
    clk_en && cpu_req.valid && cpu_req.write && !cpu_req.tag_update && !next_wfault && !next_ufault
      |=> access_flags.cache_write_dirty;
  endproperty
  a_dirty: assert property (p_dirty) else $error("dirty not asserted on write");

  property p_hit_needs_match;
    (access_flags.virt_hit |-> access_flags.virt_tag_match)
      and (access_flags.phys_hit |-> access_flags.phys_tag_match && access_flags.translation_match);
  endproperty
  a_hit_needs_match: assert property (p_hit_needs_match) else $error("hit without match");

  property p_idle;
    clk_en && !cpu_req.valid |=> access_flags == '0 && bank_chip_select == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("outputs active while idle");

  property p_cov_hit;
    access_flags.virt_hit && access_flags.phys_hit;
  endproperty
  c_cov_hit: cover property (p_cov_hit);

  property p_cov_fault;
    access_flags.write_fault || access_flags.user_fault;
  endproperty
  c_cov_fault: cover property (p_cov_fault);

  property p_cov_halves;
    clk_en && cache_store && !cpu_req.addr[2] ##1 clk_en && cache_store && cpu_req.addr[2];
  endproperty
  c_cov_halves: cover property (p_cov_halves);

endmodule : tlct_top
`default_nettype wire

// ### sim/tlct_cpu_model.sv
`default_nettype none
module tlct_cpu_model (
  input  wire logic                 clk_sys,
  output tlct_pkg::tlct_cpu_req_type cpu_req,
  output logic                      consist_hold,
  output logic                      diag_read
);
  timeunit 1ns;
  timeprecision 1ps;
  import tlct_pkg::*;
  initial begin
    cpu_req = '0;
    consist_hold = 1'b0;
    diag_read = 1'b0;
  end
  // One bus cycle per call, changed just after the edge
  task automatic issue(input tlct_cpu_req_type r, input logic h, input logic d);
    @(posedge clk_sys);
    cpu_req <= r;
    consist_hold <= h;
    diag_read <= d;
  endtask : issue
endmodule : tlct_cpu_model
`default_nettype wire

// ### sim/tb.sv
`default_nettype none
`include "tlct_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tlct_pkg::*;
  logic               clk_sys = 1'b0, rstn = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic               awr, wr, bv, arr, rv, hold, diag, xl, vhe, ce = 1'b1;
  logic [1:0]         bresp, rresp;
  logic [7:0]         awa = 8'h00, ara = 8'h00, sid, cs;
  logic [31:0]        wd = 32'h0, rd, pa, dlo, dhi, cdb, elo, ehi, lf;
  tlct_cpu_req_type   req;
  tlct_flags_type     fl;
  tlct_tlb_entry_type tlb [8];
  tlct_tag_entry_type tags [int];
  int                 mismatches = 0, compares = 0, cyc = 0;
  tlct_top uut (.clk_sys(clk_sys), .rstn(rstn), .clk_en(ce), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .cpu_req(req), .consist_hold(hold), .diag_read(diag), .access_flags(fl), .physical_address_bus(pa),
    .latched_space_id(sid), .bank_chip_select(cs), .cache_data_low(dlo), .cache_data_high(dhi),
    .control_data_bus(cdb));
  tlct_cpu_model u_cpu (.clk_sys(clk_sys), .cpu_req(req), .consist_hold(hold), .diag_read(diag));
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      end_of_test();
    end
  end
  function automatic logic [31:0] rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : rnd
  task automatic end_of_test();
    if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [95:0] g, input logic [95:0] e, input string m);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ah, wh, bh;
    @(posedge clk_sys);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      @(negedge clk_sys);
      ah = awv & awr;
      wh = wv & wr;
      bh = bv;
      if (bh) chk(bresp, er, "bresp");
      @(posedge clk_sys);
      if (ah) awv <= 1'b0;
      if (wh) wv <= 1'b0;
    end
    br <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ah, dh;
    @(posedge clk_sys);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    dh = 1'b0;
    while (!dh) begin
      @(negedge clk_sys);
      ah = arv & arr;
      dh = rv;
      if (dh) chk({rresp, rd}, {er, ed}, "read");
      @(posedge clk_sys);
      if (ah) arv <= 1'b0;
    end
    rr <= 1'b0;
  endtask : axr
  task automatic ctl(input logic [31:0] v);
    axw(`TLCT_OFF_CTRL, v, 2'b00);
    xl = v[0];
    vhe = v[1];
  endtask : ctl
  task automatic acc(input logic w, input logic u, input logic tu, input logic [7:0] s,
                     input logic [31:0] a, input logic [31:0] d, input logic h);
    tlct_flags_type     ef;
    tlct_tag_entry_type t;
    tlct_tlb_entry_type e;
    logic [31:0]        ea;
    e = tlb[a[15:13]];
    t = tags.exists(a[15:5]) ? tags[a[15:5]] : '0;
    ef.translation_match = !xl || (e.valid && e.vtag == a[31:16]);
    ea = !xl ? a : (ef.translation_match ? {e.ppn, a[12:0]} : 32'h0);
    ef.write_fault = xl && ef.translation_match && w && e.write_protect;
    ef.user_fault = xl && ef.translation_match && u && e.super_only;
    ef.virt_tag_match = t.vtag == a[31:16];
    ef.phys_tag_match = ef.translation_match && t.ptag == ea[31:13];
    ef.virt_hit = ef.virt_tag_match && t.virt_valid && s[7:2] == 6'h02 && vhe && !h;
    ef.phys_hit = ef.translation_match && ef.phys_tag_match && t.phys_valid && !h;
    ef.virt_miss = !ef.virt_hit;
    ef.phys_miss = !ef.phys_hit;
    ef.cache_write_dirty = w && !tu && !ef.write_fault && !ef.user_fault;
    u_cpu.issue('{1'b1, w, u, tu, s, a, d}, h, 1'b0);
    u_cpu.issue('{1'b0, w, u, tu, ~s, ~a, ~d}, 1'b0, 1'b1);
    #1;
    chk(fl, ef, "flags");
    chk(pa, ea, "paddr");
    chk(sid, s, "space");
    chk(cs, 8'h01 << a[2:0], "csel");
    if (ef.cache_write_dirty && a[2]) ehi = d;
    if (ef.cache_write_dirty && !a[2]) elo = d;
    chk({dhi, dlo}, {ehi, elo}, "data");
    if (tu) tags[a[15:5]] = '{ef.translation_match, 1'b1, w, a[31:16], ea[31:13]};
    @(posedge clk_sys);
    #1;
    chk(cdb, {s, 8'h01 << a[2:0], 6'h0, ef}, "test");
    chk({fl, cs}, 18'h0, "idle");
  endtask : acc
  initial begin
    xl = 1'b1;
    vhe = 1'b1;
    elo = '0;
    ehi = '0;
    lf = 32'd84301;
    foreach (tlb[i]) tlb[i] = '0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    #1 chk({fl, cs, pa, dlo}, '0, "reset");
    axr(`TLCT_OFF_CTRL, `TLCT_CTRL_RESET, 2'b00);
    axr(8'h40, 32'h0, 2'b10);
    axw(8'h40, 32'h0, 2'b10);
    ctl(32'h2);
    for (int i = 0; i < 8; i++) begin
      lf = rnd(lf);
      acc(1'b1, 1'b0, 1'b0, 8'h0a, {lf[31:3], i[2:0]}, ~lf, 1'b0);
    end
    for (int k = 0; k < 2; k++) begin
      lf = rnd(lf);
      acc(1'b0, 1'b0, 1'b1, 8'h0a, lf, 32'h0, 1'b0);
      for (int i = 7; i < 13; i++) acc(1'b0, 1'b0, 1'b0, i == 12 ? 8'h09 : i[7:0], lf, 32'h0, i == 12);
      acc(1'b1, 1'b0, 1'b0, 8'h08, lf ^ 32'h0001_0000, lf, 1'b0);
      if (k == 0) begin
        ctl(32'h3);
        axw(`TLCT_OFF_TLB_IDX, {29'h0, lf[31:29]}, 2'b00);
        axw(`TLCT_OFF_TLB_VTAG, {16'h0, lf[15:0]} ^ 32'h0000_5a5a, 2'b00);
        axw(`TLCT_OFF_TLB_PPN, 32'ha002a5b3, 2'b00);
        lf = {lf[15:0] ^ 16'h5a5a, lf[31:29], lf[12:0]};
        tlb[lf[15:13]] = '{1'b1, 1'b1, 1'b0, lf[31:16], 19'h2a5b3};
        acc(1'b1, 1'b0, 1'b0, 8'h0b, lf, 32'h1234_5678, 1'b0);
        acc(1'b0, 1'b0, 1'b0, 8'h0b, lf ^ 32'h8000_0000, 32'h0, 1'b0);
        axr(`TLCT_OFF_LAST_PA, 32'h0, 2'b00);
      end
    end
    ctl(32'h1);
    acc(1'b0, 1'b0, 1'b0, 8'h08, lf, 32'h0, 1'b0);
    // Tag update followed at once by a lookup of the same line
    u_cpu.issue('{1'b1, 1'b0, 1'b0, 1'b1, 8'h0a, lf ^ 32'h0000_0020, 32'h0}, 1'b0, 1'b0);
    u_cpu.issue('{1'b1, 1'b0, 1'b0, 1'b0, 8'h0a, lf ^ 32'h0000_0020, 32'h0}, 1'b0, 1'b0);
    u_cpu.issue('0, 1'b0, 1'b0);
    #1 chk(fl.virt_tag_match, 1'b1, "tag back");
    // Access held off while the clock enable is low
    u_cpu.issue('{1'b1, 1'b0, 1'b0, 1'b0, 8'h05, 32'h0000_0004, 32'h0}, 1'b0, 1'b0);
    ce <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 chk({fl, cs, sid}, {18'h0, 8'h0a}, "freeze");
    @(posedge clk_sys);
    ce <= 1'b1;
    u_cpu.issue('0, 1'b0, 1'b0);
    #1 chk({cs, sid}, {8'h10, 8'h05}, "thaw");
    end_of_test();
  end
endmodule : tb
`default_nettype wire
